// *** rtl/sfc_consts.svh ***
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define SFC_IDX_EP8_CFG      16'hE615
`define SFC_IDX_EP2_FIFO_CFG 16'hE618
`define SFC_IDX_EP4_FIFO_CFG 16'hE619
`define SFC_IDX_EP6_FIFO_CFG 16'hE61A
`define SFC_IDX_EP8_FIFO_CFG 16'hE61B
`define SFC_IDX_EP2_LEN_H    16'hE620
`define SFC_IDX_EP2_LEN_L    16'hE621
`define SFC_IDX_EP4_LEN_H    16'hE622
`define SFC_IDX_EP4_LEN_L    16'hE623
`define SFC_IDX_EP6_LEN_H    16'hE624
`define SFC_IDX_EP6_LEN_L    16'hE625
`define SFC_IDX_EP8_LEN_H    16'hE626
`define SFC_IDX_EP8_LEN_L    16'hE627
// own registers: fifo event control and status
`define SFC_IDX_FIFO_CTRL    16'hE640
`define SFC_IDX_FIFO_STAT    16'hE641
// reset values
`define SFC_RST_EP8_CFG      8'hE0
`define SFC_RST_FIFO_CFG     8'h05
`define SFC_RST_LEN_H        8'h02
`define SFC_RST_LEN_L        8'h00
// field positions in the fifo configuration byte
`define SFC_BIT_INFM         6
`define SFC_BIT_OEP          5
`define SFC_BIT_AOUT         4
`define SFC_BIT_AIN          3
`define SFC_BIT_ZLEN         2
`define SFC_BIT_WIDE         0
// field positions in the endpoint configuration byte
`define SFC_BIT_EP_VALID     7
`define SFC_BIT_EP_DIR       6
`define SFC_BIT_EP_TYPE      4
// writable masks
`define SFC_MASK_EP8_CFG     8'hF0
`define SFC_MASK_FIFO_CFG    8'h7D
`define SFC_MASK_LEN_H_WIDE  8'h07
`define SFC_MASK_LEN_H_NARW  8'h03
// endpoint type codes
`define SFC_TYPE_ISO         2'h1
`define SFC_TYPE_BULK        2'h2
`define SFC_TYPE_INT         2'h3
`endif

// *** rtl/sfc_pkg.sv ***
package sfc_pkg;
   // one-hot packetiser states
   typedef enum logic [2:0] {
      SFC_IDLE = 3'b001,
      SFC_FILL = 3'b010,
      SFC_SEND = 3'b100
   } sfc_state_t;
   typedef logic [7:0] sfc_byte_t;
endpackage : sfc_pkg

// *** rtl/sfc_skid.sv ***
`timescale 1ns/1ps
// two-entry buffer; a downstream stall loses no word
module sfc_skid
   import sfc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem [0:1];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         case ({push, pop})
            2'b10:   count <= count + 2'h1;
            2'b01:   count <= count - 2'h1;
            default: count <= count;
         endcase
      end
   end
endmodule : sfc_skid

// *** rtl/sfc_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - in_full_minus_one set raises the full flag one byte before the fifo is full.
// - out_empty_plus_one set raises the empty flag while one byte is still left.
// - auto_commit_out set commits every valid out packet to the fifo at once.
// - auto_commit_out clear holds a received packet until firmware commits it.
// - auto_dispatch_in set cuts in data into packets of the programmed length.
// - auto_dispatch_in clear sends a packet only when firmware writes its byte count.
// - word_wide_a set puts data bits 7:0 on port_b and bits 15:8 on port_d.
// - any word_wide_a bit among the four endpoints makes port_d the upper data byte.
// - zero_length_in_enable with packet_end on an empty in fifo sends a zero-length packet.
// - the automatic packet length resets to 512 and may be made smaller.
// - endpoints 2 and 6 hold an 11-bit length, endpoints 4 and 8 a 10-bit length.
// - the length registers steer packetising only while auto_dispatch_in is set.
// - endpoint 8 configuration resets to a valid bulk in endpoint.
// - type 01 is iso, 10 bulk, 11 interrupt, 00 illegal; direction set means in.
`include "sfc_consts.svh"
module sfc_top
   import sfc_pkg::*;
#(
   parameter int DEPTH = 1024
) (
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [17:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic [1:0]  EP_SEL_IN,
   input  wire logic [15:0] IN_DATA_IN,
   input  wire logic        IN_WRITE_IN,
   input  wire logic        PACKET_END_IN,
   input  wire logic        OUT_PKT_VALID_IN,
   output logic             FULL_FLAG_OUT,
   output logic             EMPTY_FLAG_OUT,
   output logic             WORD_MODE_OUT,
   output logic             PORT_D_FIFO_OUT,
   output logic             OUT_COMMIT_OUT,
   output logic [15:0]      SIE_DATA_OUT,
   output logic             SIE_VALID_OUT,
   input  wire logic        SIE_READY_IN,
   output logic             SIE_PKT_END_OUT,
   output logic             SIE_ZLP_OUT,
   output logic [10:0]      SIE_PKT_LEN_OUT
);
   localparam int CW = $clog2(DEPTH + 1);

   // register bank
   sfc_byte_t   ep8_cfg;
   sfc_byte_t   fifo_cfg [0:3];
   sfc_byte_t   len_h    [0:3];
   sfc_byte_t   len_l    [0:3];
   logic [10:0] manual_len;
   logic        manual_go;
   logic        fw_commit;
   logic [CW-1:0] level;
   // packetiser and fifo side
   sfc_state_t  state;
   logic [10:0] sent;
   logic [10:0] target;
   sfc_byte_t   cur_cfg;
   logic        any_wide;
   logic        wr_take;
   logic        rd_take;
   logic [15:0] buf_data;
   logic        buf_valid;
   logic        buf_ready;
   logic        pkt_done;
   logic [1:0]  inc;
   logic [31:0] next_rdata;
   logic        mapped;
   logic        manual_run;
   logic        fill_ok;

   // 11-bit field for endpoints 2 and 6, 10-bit for 4 and 8
   function automatic sfc_byte_t len_h_mask(input logic [1:0] ep);
      len_h_mask = ep[0] ? `SFC_MASK_LEN_H_NARW : `SFC_MASK_LEN_H_WIDE;
   endfunction : len_h_mask

   // byte address decode: index times four
   function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   // endpoint kind for status: valid with a legal type, direction in, bulk
   function automatic logic [2:0] ep_kind(input sfc_byte_t cfg);
      logic [1:0] kind;
      kind    = cfg[`SFC_BIT_EP_TYPE +: 2];
      ep_kind = {cfg[`SFC_BIT_EP_VALID] && (kind != 2'h0), cfg[`SFC_BIT_EP_DIR],
                 kind == `SFC_TYPE_BULK};
   endfunction : ep_kind

   assign cur_cfg  = fifo_cfg[EP_SEL_IN];
   assign any_wide = fifo_cfg[0][`SFC_BIT_WIDE] | fifo_cfg[1][`SFC_BIT_WIDE]
                   | fifo_cfg[2][`SFC_BIT_WIDE] | fifo_cfg[3][`SFC_BIT_WIDE];
   assign wr_take  = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
   assign inc      = cur_cfg[`SFC_BIT_WIDE] ? 2'h2 : 2'h1;
   assign target   = cur_cfg[`SFC_BIT_AIN] ? {len_h[EP_SEL_IN][2:0], len_l[EP_SEL_IN]}
                                           : manual_len;
   assign pkt_done = (sent + {9'h0, inc} >= target);

   // configuration registers, masked on write
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         ep8_cfg <= `SFC_RST_EP8_CFG;
         for (int i = 0; i < 4; i++) begin
            fifo_cfg[i] <= `SFC_RST_FIFO_CFG;
            len_h[i]    <= `SFC_RST_LEN_H;
            len_l[i]    <= `SFC_RST_LEN_L;
         end
      end else if (wr_take) begin
         if (hit(PADDR_IN, `SFC_IDX_EP8_CFG)) begin
            ep8_cfg <= PWDATA_IN[7:0] & `SFC_MASK_EP8_CFG;
         end
         for (int i = 0; i < 4; i++) begin
            if (hit(PADDR_IN, `SFC_IDX_EP2_FIFO_CFG + 16'(i))) begin
               fifo_cfg[i] <= PWDATA_IN[7:0] & `SFC_MASK_FIFO_CFG;
            end
            if (hit(PADDR_IN, `SFC_IDX_EP2_LEN_H + 16'(2 * i))) begin
               len_h[i] <= PWDATA_IN[7:0] & len_h_mask(2'(i));
            end
            if (hit(PADDR_IN, `SFC_IDX_EP2_LEN_L + 16'(2 * i))) begin
               len_l[i] <= PWDATA_IN[7:0];
            end
         end
      end
   end

   // firmware byte count and commit strobes; pulse for one cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         manual_len <= 11'h000;
         manual_go  <= 1'b0;
         fw_commit  <= 1'b0;
      end else begin
         manual_go <= 1'b0;
         fw_commit <= 1'b0;
         if (wr_take && hit(PADDR_IN, `SFC_IDX_FIFO_CTRL)) begin
            manual_len <= PWDATA_IN[10:0];
            manual_go  <= PWDATA_IN[16];
            fw_commit  <= PWDATA_IN[17];
         end
      end
   end

   // read mux; unmapped reads zero with an error
   always_comb begin
      next_rdata = 32'h0000_0000;
      mapped     = 1'b1;
      if (hit(PADDR_IN, `SFC_IDX_EP8_CFG)) begin
         next_rdata[7:0] = ep8_cfg;
      end else if (hit(PADDR_IN, `SFC_IDX_FIFO_CTRL)) begin
         next_rdata[10:0] = manual_len;
      end else if (hit(PADDR_IN, `SFC_IDX_FIFO_STAT)) begin
         next_rdata = {13'h0, ep_kind(ep8_cfg), state, FULL_FLAG_OUT, EMPTY_FLAG_OUT, sent};
      end else begin
         mapped = 1'b0;
         for (int i = 0; i < 4; i++) begin
            if (hit(PADDR_IN, `SFC_IDX_EP2_FIFO_CFG + 16'(i))) begin
               next_rdata[7:0] = fifo_cfg[i];
               mapped = 1'b1;
            end
            if (hit(PADDR_IN, `SFC_IDX_EP2_LEN_H + 16'(2 * i))) begin
               next_rdata[7:0] = len_h[i];
               mapped = 1'b1;
            end
            if (hit(PADDR_IN, `SFC_IDX_EP2_LEN_L + 16'(2 * i))) begin
               next_rdata[7:0] = len_l[i];
               mapped = 1'b1;
            end
         end
      end
   end

   // apb answer: one wait state, ready in the access cycle's second edge
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PREADY_OUT  <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
         PSLVERR_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT && !mapped;
         if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
            PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   // in fifo fill level; the master writes bytes or words
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         level <= '0;
      end else begin
         level <= level + (wr_take_in() ? CW'(inc) : '0) - (rd_take ? CW'(inc) : '0);
      end
   end

   // the registered flag lags a cycle, so room is checked on the live level too
   function automatic logic wr_take_in();
      wr_take_in = IN_WRITE_IN && !FULL_FLAG_OUT
                   && (level + CW'(inc) <= CW'(DEPTH));
   endfunction : wr_take_in

   // flags registered; early variants look one byte ahead
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         FULL_FLAG_OUT  <= 1'b0;
         EMPTY_FLAG_OUT <= 1'b1;
      end else begin
         FULL_FLAG_OUT  <= cur_cfg[`SFC_BIT_INFM] ? (level + CW'(1) >= CW'(DEPTH))
                                                  : (level >= CW'(DEPTH));
         EMPTY_FLAG_OUT <= cur_cfg[`SFC_BIT_OEP] ? (level <= CW'(1))
                                                 : (level == '0);
      end
   end

   // port mapping and out commit
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         WORD_MODE_OUT   <= 1'b0;
         PORT_D_FIFO_OUT <= 1'b0;
         OUT_COMMIT_OUT  <= 1'b0;
      end else begin
         WORD_MODE_OUT   <= cur_cfg[`SFC_BIT_WIDE];
         PORT_D_FIFO_OUT <= any_wide;
         OUT_COMMIT_OUT  <= cur_cfg[`SFC_BIT_AOUT] ? OUT_PKT_VALID_IN
                                                   : fw_commit;
      end
   end

   // packetiser: drain words toward the engine through the buffer
   assign fill_ok = cur_cfg[`SFC_BIT_AIN] || manual_run;
   assign rd_take = (state == SFC_FILL) && fill_ok && (level >= CW'(inc)) && buf_ready;

   // a firmware packet stays armed until sent; clearing the auto bit abandons
   // an automatic packet, words already handed on are not recalled
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         manual_run <= 1'b0;
      end else if (state == SFC_IDLE) begin
         manual_run <= manual_go;
      end else if (state == SFC_SEND) begin
         manual_run <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         state <= SFC_IDLE;
         sent  <= 11'h000;
      end else begin
         case (state)
            SFC_IDLE: begin
               sent <= 11'h000;
               if (cur_cfg[`SFC_BIT_AIN] || manual_go) begin
                  state <= SFC_FILL;
               end
            end
            SFC_FILL: begin
               if (!fill_ok) begin
                  state <= SFC_IDLE;
               end else if (rd_take) begin
                  sent <= sent + {9'h0, inc};
                  if (pkt_done) begin
                     state <= SFC_SEND;
                  end
               end
            end
            SFC_SEND: state <= SFC_IDLE;
            default:  state <= SFC_IDLE;
         endcase
      end
   end

   // packet end and zero-length packet
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         SIE_PKT_END_OUT <= 1'b0;
         SIE_ZLP_OUT     <= 1'b0;
         SIE_PKT_LEN_OUT <= 11'h000;
      end else begin
         SIE_PKT_END_OUT <= (state == SFC_SEND);
         SIE_ZLP_OUT     <= PACKET_END_IN && (level == '0)
                            && fifo_cfg[EP_SEL_IN][`SFC_BIT_ZLEN];
         if (state == SFC_SEND) begin
            SIE_PKT_LEN_OUT <= sent;
         end
      end
   end

   sfc_skid #(
      .WIDTH (16)
   ) u_skid (
      .clk       (SYS_CLK_IN),
      .rst_n     (RST_N_IN),
      .in_data   (IN_DATA_IN),
      .in_valid  (rd_take),
      .in_ready  (buf_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (SIE_READY_IN || !SIE_VALID_OUT)
   );

   // output stage register toward the engine
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         SIE_DATA_OUT  <= 16'h0000;
         SIE_VALID_OUT <= 1'b0;
      end else if (SIE_READY_IN || !SIE_VALID_OUT) begin
         SIE_DATA_OUT  <= buf_data;
         SIE_VALID_OUT <= buf_valid;
      end
   end
endmodule : sfc_top

// *** sim/sfc_master_model.sv ***
`timescale 1ns/1ps
// external master on the slave fifo pins
module sfc_master_model (
   input  wire logic   clk_in,
   output logic [15:0] data_out,
   output logic        write_out,
   output logic        pkt_end_out
);
   initial begin
      data_out = 16'h0000;
      write_out = 1'b0;
      pkt_end_out = 1'b0;
   end
   // one byte; bus shows inverted data once released
   task put;
      @(posedge clk_in);
      data_out <= 16'($urandom);
      write_out <= 1'b1;
      @(posedge clk_in);
      write_out <= 1'b0;
      data_out <= ~data_out;
      repeat (3) @(posedge clk_in);
   endtask : put
   // packet end strobe for one cycle
   task endpkt;
      @(posedge clk_in);
      pkt_end_out <= 1'b1;
      @(posedge clk_in);
      pkt_end_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask : endpkt
endmodule : sfc_master_model

// *** sim/sfc_top_props.sv ***
`timescale 1ns/1ps
// port-level checks on the configuration bank and its fifo side
module sfc_top_props (
   input wire logic        SYS_CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic        PACKET_END_IN,
   input wire logic        FULL_FLAG_OUT,
   input wire logic        EMPTY_FLAG_OUT,
   input wire logic        WORD_MODE_OUT,
   input wire logic        PORT_D_FIFO_OUT,
   input wire logic        OUT_COMMIT_OUT,
   input wire logic        SIE_PKT_END_OUT,
   input wire logic        SIE_ZLP_OUT,
   input wire logic [10:0] SIE_PKT_LEN_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // one wait state on every access
   property p_ready; PSEL_IN && $rose(PENABLE_IN) |-> ##1 PREADY_OUT; endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_ready_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready stuck");
   property p_err; PSLVERR_OUT |-> PREADY_OUT && PSEL_IN; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   // a zero-length packet needs packet end on an empty fifo
   property p_zlp; SIE_ZLP_OUT |-> $past(PACKET_END_IN) && $past(EMPTY_FLAG_OUT); endproperty
   a_zlp: assert property (p_zlp) else $error("stray zero packet");
   property p_wide; WORD_MODE_OUT |-> PORT_D_FIFO_OUT; endproperty
   a_wide: assert property (p_wide) else $error("port d not upper byte");
   property p_flags; !(FULL_FLAG_OUT && EMPTY_FLAG_OUT); endproperty
   a_flags: assert property (p_flags) else $error("full and empty");
   property p_commit; OUT_COMMIT_OUT |=> !OUT_COMMIT_OUT; endproperty
   a_commit: assert property (p_commit) else $error("commit stuck");
   property p_pkt; SIE_PKT_END_OUT |-> SIE_PKT_LEN_OUT <= 11'h400 ##1 !SIE_PKT_END_OUT; endproperty
   a_pkt: assert property (p_pkt) else $error("bad packet end");
endmodule : sfc_top_props

// *** sim/sfc_top_test.sv ***
`timescale 1ns/1ps
module sfc_top_test;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        sie_ready = 0, out_valid = 0, err;
   logic [1:0]  ep_sel = 0;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, v;
   logic        pready, pslverr, full, empty, wmode, portd, commit, sie_valid, pkt_end, zlp;
   logic [15:0] in_data, sie_data, idx, m;
   logic        in_write, pend;
   logic [10:0] pkt_len, last_len;
   int          num_errors = 0, compares = 0, zlps = 0, commits = 0, pkts = 0, base;
   int          words = 0;

   sfc_top #(.DEPTH(8)) u_sfc_top (
      .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EP_SEL_IN(ep_sel), .IN_DATA_IN(in_data),
      .IN_WRITE_IN(in_write), .PACKET_END_IN(pend), .OUT_PKT_VALID_IN(out_valid),
      .FULL_FLAG_OUT(full), .EMPTY_FLAG_OUT(empty), .WORD_MODE_OUT(wmode),
      .PORT_D_FIFO_OUT(portd), .OUT_COMMIT_OUT(commit), .SIE_DATA_OUT(sie_data),
      .SIE_VALID_OUT(sie_valid), .SIE_READY_IN(sie_ready), .SIE_PKT_END_OUT(pkt_end),
      .SIE_ZLP_OUT(zlp), .SIE_PKT_LEN_OUT(pkt_len));
   sfc_master_model u_sfc_master_model (.clk_in(clk), .data_out(in_data),
      .write_out(in_write), .pkt_end_out(pend));

   always #20 clk = ~clk;
   // random back-pressure from the serial engine side
   always @(posedge clk) sie_ready <= ($urandom % 4) != 0;
   // pulse counters
   always @(posedge clk) begin
      if (zlp === 1'b1) zlps++;
      if (commit === 1'b1) commits++;
      if (sie_valid === 1'b1 && sie_ready === 1'b1) words++;
      if (pkt_end === 1'b1) begin
         pkts++;
         last_len = pkt_len;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until ready is sampled
   task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wait_pkt(input int n);
      int c = 0;
      while (pkts < n && c++ < 300) @(posedge clk);
      chk(pkts, n);
   endtask : wait_pkt
   task automatic end_sim;
      if (num_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // reset value in the high byte, writable mask in the low byte
   function automatic logic [15:0] rinfo(input logic [15:0] i);
      case (i)
         16'hE615: return 16'hE0F0;
         16'hE620, 16'hE624: return 16'h0207;
         16'hE622, 16'hE626: return 16'h0203;
         default: return i < 16'hE620 ? 16'h057D : 16'h00FF;
      endcase
   endfunction : rinfo

   initial begin
      void'($urandom(32'h0099));
      tick(3);
      rst_n <= 1;
      for (int k = 0; k < 13; k++) begin
         idx = k == 0 ? 16'hE615 : (k < 5 ? 16'hE617 + k : 16'hE61B + k);
         m = rinfo(idx);
         apb(0, idx, 0);
         chk(rd, m[15:8]);
         v = $urandom;
         apb(1, idx, v);
         apb(0, idx, 0);
         chk(rd, v & m[7:0]);
      end
      apb(0, 16'hE616, 0);
      chk({rd[30:0], err}, 1);
      // endpoint kind decode: iso out, then a valid entry with the illegal type
      apb(1, 16'hE615, 32'h90);
      apb(0, 16'hE641, 0);
      chk(rd[18:16], 3'h4);
      apb(1, 16'hE615, 32'hC0);
      apb(0, 16'hE641, 0);
      chk(rd[18:16], 3'h2);
      // second reset in mid-run brings back the bulk in default and word width
      rst_n <= 0;
      tick(3);
      rst_n <= 1;
      apb(0, 16'hE641, 0);
      chk(rd[18:16], 3'h7);
      apb(0, 16'hE615, 0);
      chk(rd, 32'hE0);
      chk({wmode, portd}, 3);
      // port d follows any word-wide bit
      for (int k = 0; k < 4; k++) apb(1, 16'hE618 + k, 0);
      tick(3);
      chk({wmode, portd}, 0);
      apb(1, 16'hE61B, 1);
      ep_sel <= 3;
      tick(3);
      chk({wmode, portd}, 3);
      ep_sel <= 0;
      tick(3);
      chk({wmode, portd}, 1);
      apb(1, 16'hE61B, 0);
      // flags normal and one early, then manual dispatch of the level
      for (int f = 0; f < 2; f++) begin
         apb(1, 16'hE618, f ? 32'h60 : 0);
         tick(3);
         for (int l = 1; l <= 8 - f; l++) begin
            u_sfc_master_model.put();
            chk({full, empty}, {l >= 8 - f, l <= f});
         end
         base = pkts;
         apb(1, 16'hE640, 32'h10000 + 8 - f);
         wait_pkt(base + 1);
         chk(last_len, 8 - f);
      end
      // automatic dispatch in four-byte packets, then zero-length packets with and without the enable
      apb(1, 16'hE620, 0);
      apb(1, 16'hE621, 4);
      apb(1, 16'hE618, 32'h08);
      base = pkts;
      repeat (8) u_sfc_master_model.put();
      wait_pkt(base + 2);
      chk(last_len, 4);
      tick(20);
      apb(1, 16'hE618, 32'h04);
      base = zlps;
      u_sfc_master_model.endpkt();
      chk(zlps, base + 1);
      apb(1, 16'hE618, 0);
      u_sfc_master_model.endpkt();
      chk(zlps, base + 1);
      // out packets: automatic, held, then firmware commit
      apb(1, 16'hE618, 32'h10);
      base = commits;
      out_valid <= 1;
      tick(1);
      out_valid <= 0;
      tick(3);
      chk(commits, base + 1);
      apb(1, 16'hE618, 0);
      out_valid <= 1;
      tick(1);
      out_valid <= 0;
      tick(3);
      chk(commits, base + 1);
      apb(1, 16'hE640, 32'h20000);
      tick(3);
      chk(commits, base + 2);
      chk(words, 23);
      end_sim();
   end

   // hang guard, well beyond the expected run
   initial begin
      tick(20000);
      num_errors++;
      end_sim();
   end
endmodule : sfc_top_test

bind sfc_top sfc_top_props u_sfc_top_props (.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .PACKET_END_IN(PACKET_END_IN), .FULL_FLAG_OUT(FULL_FLAG_OUT),
   .EMPTY_FLAG_OUT(EMPTY_FLAG_OUT), .WORD_MODE_OUT(WORD_MODE_OUT),
   .PORT_D_FIFO_OUT(PORT_D_FIFO_OUT), .OUT_COMMIT_OUT(OUT_COMMIT_OUT),
   .SIE_PKT_END_OUT(SIE_PKT_END_OUT), .SIE_ZLP_OUT(SIE_ZLP_OUT),
   .SIE_PKT_LEN_OUT(SIE_PKT_LEN_OUT));
